// >>> rtl/process_control_channels_params.svh
`ifndef PROCESS_CONTROL_CHANNELS_PARAMS_SVH
`define PROCESS_CONTROL_CHANNELS_PARAMS_SVH

// channel count
`define PCC_NCH 8
// register byte offsets (12-bit decode window)
`define PCC_OFS_CTRL 12'h000
`define PCC_OFS_MODE 12'h004
`define PCC_OFS_STATE 12'h008
`define PCC_OFS_INT_STATUS 12'h00C
`define PCC_OFS_INT_MASK 12'h010
// per-channel rule blocks: 0x080 + channel * 0x10
`define PCC_OFS_CH_BASE 12'h080
`define PCC_CH_FLD_CFG 2'h0
`define PCC_CH_FLD_SETPOINT 2'h1
`define PCC_CH_FLD_HYST 2'h2
`define PCC_CH_FLD_DELAY 2'h3
// field positions
`define PCC_CTRL_POWER_BIT 0
`define PCC_STATE_AUTO_LSB 8
`define PCC_STATE_POWER_BIT 16
// source selector codes
`define PCC_SRC_VOLT 5'h08
`define PCC_SRC_MANO 5'h0C
`define PCC_SRC_CLOCK 5'h10
`define PCC_SRC_LOGIC 5'h11
`define PCC_SRC_ALARM 5'h18
// reset values
`define PCC_RST_WORD16 16'h0000
`define PCC_RST_MASK 8'h00
// timing: rule delays count in ticks of one millisecond
`define PCC_CLK_PERIOD_NS 10
`define PCC_TICK_PERIOD_NS 1000000
`define PCC_TICK_CYCLES (`PCC_TICK_PERIOD_NS / `PCC_CLK_PERIOD_NS)

`endif

// >>> rtl/process_control_channels_pkg.sv
package process_control_channels_pkg;

  // channel control selection
  typedef enum logic [1:0] {
    MODE_MAN_OFF = 2'b00,
    MODE_MAN_ON = 2'b01,
    MODE_AUTO = 2'b11
  } chan_mode_t;

  // automatic channel states, gray along inactive-arming-active-releasing
  typedef enum logic [1:0] {
    ST_INACTIVE = 2'b00,
    ST_ARMING = 2'b01,
    ST_ACTIVE = 2'b11,
    ST_RELEASING = 2'b10
  } chan_state_t;

  // rule configuration word
  typedef struct packed {
    logic audio_deact;
    logic audio_act;
    logic fallback;
    logic polarity;
    logic [4:0] src;
  } rule_cfg_t;

  // readings available as sources
  typedef struct packed {
    logic [7:0][15:0] pressure;
    logic [3:0][15:0] voltage_analog_inputs;
    logic [3:0][15:0] manometer_analog_inputs;
    logic [15:0] clock_minutes;
    logic [7:0] alarm;
  } sources_t;

  // health of the measuring instruments and analog ports
  typedef struct packed {
    logic [7:0] pressure_fail;
    logic [7:0] analog_is_output;
    logic [7:0] analog_overload;
    logic gas_analyzer_head_busy;
  } health_t;

  // fetched source sample
  typedef struct packed {
    logic fail;
    logic freeze;
    logic [15:0] value;
  } src_sample_t;

endpackage

// >>> rtl/process_control_channels.sv
// Function
// - eight independent channels, relay plus logic output
// - manual override or automatic rule per channel
// - auto source: pressure, analog, clock, logic, alarm
// - rule: source, setpoint, polarity, hysteresis, delay, audio
// - pressure source off or faulted forces fallback
// - manual active/inactive forces state, leaves auto
// - auto hands state back to rule evaluation
// - power-on: all manual inactive
// - analog source as output or overloaded: fallback
// - power loss de-energizes every relay
// - stays off until explicit turn-on command
// - active: logic low, relay on, led on
// - analyzer busy freezes analyzer-sourced channels
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "process_control_channels_params.svh"

module process_control_channels #(
  parameter int unsigned TICK_CYCLES = `PCC_TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire process_control_channels_pkg::sources_t sources,
  input wire process_control_channels_pkg::health_t health,
  input wire logic [6:0] logic_in_pins,
  output logic [7:0] relay_drive,
  output logic [7:0] logic_out_n,
  output logic [7:0] led,
  output logic [7:0] audio_alert,
  output logic powered,
  output logic irq
);
  import process_control_channels_pkg::*;

  // bus state
  logic wr_pend_q; // write data phase in progress
  logic [11:0] wr_addr_q; // latched write offset
  logic rd_pend_q; // read wait cycle in progress
  logic [11:0] rd_addr_q; // latched read offset
  logic [31:0] hrdata_q; // read data
  logic hready_q; // ready output
  // control registers
  logic power_q; // device turned on
  chan_mode_t mode_q [`PCC_NCH]; // per-channel mode
  rule_cfg_t cfg_q [`PCC_NCH]; // per-channel rule configuration
  logic [15:0] setpoint_q [`PCC_NCH]; // activation level
  logic [15:0] hyst_q [`PCC_NCH]; // hysteresis band
  logic [15:0] delay_q [`PCC_NCH]; // delay in ticks
  logic [7:0] int_stat_q; // sticky change events
  logic [7:0] int_mask_q; // interrupt enables
  logic irq_q; // interrupt output
  // channel state
  chan_state_t st_q [`PCC_NCH]; // channel state machines
  logic [15:0] cnt_q [`PCC_NCH]; // delay counters
  logic [7:0] chan_on; // channel active level
  logic [7:0] relay_q; // relay drive
  logic [7:0] logic_n_q; // logic outputs, low when active
  logic [7:0] led_q; // indicators
  logic [7:0] audio_q; // audio request pulses
  logic [7:0] change_ev; // channel changed this cycle
  // pin synchroniser and tick divider
  logic [6:0] lin_meta_q; // first synchroniser stage
  logic [6:0] lin_q; // synchronised logic inputs
  logic [31:0] tick_cnt_q; // divider count
  logic tick_q; // one-cycle millisecond enable
  logic wr_en; // register write strobe
  logic [7:0] w1c_clr; // status bits cleared this cycle

  // accept a request in the address phase
  function automatic logic take(input logic sel, input logic [1:0] tr, input logic rdy);
    take = sel && tr[1] && rdy;
  endfunction

  // decode a written mode code; anything unknown reads as manual inactive
  function automatic chan_mode_t mode_decode(input logic [1:0] code);
    case (code)
      2'b01: mode_decode = MODE_MAN_ON;
      2'b11: mode_decode = MODE_AUTO;
      default: mode_decode = MODE_MAN_OFF;
    endcase
  endfunction

  // pick the source reading, its fault and its freeze condition
  function automatic src_sample_t src_fetch(input logic [4:0] sel, input sources_t s, input health_t h,
                                            input logic [6:0] lin);
    src_sample_t r;
    logic [4:0] li;
    r = '0;
    li = 5'(sel - `PCC_SRC_LOGIC);
    if (sel < `PCC_SRC_VOLT)
    begin
      // pressure readings; the first four come from the analyzer head
      r.value = s.pressure[sel[2:0]];
      r.fail = h.pressure_fail[sel[2:0]];
      r.freeze = h.gas_analyzer_head_busy && !sel[2];
    end
    else if (sel < `PCC_SRC_MANO)
    begin
      r.value = s.voltage_analog_inputs[sel[1:0]];
      r.fail = h.analog_is_output[{1'b0, sel[1:0]}] | h.analog_overload[{1'b0, sel[1:0]}];
    end
    else if (sel < `PCC_SRC_CLOCK)
    begin
      r.value = s.manometer_analog_inputs[sel[1:0]];
      r.fail = h.analog_is_output[{1'b1, sel[1:0]}] | h.analog_overload[{1'b1, sel[1:0]}];
    end
    else if (sel < `PCC_SRC_LOGIC)
    begin
      r.value = s.clock_minutes;
    end
    else if (sel < `PCC_SRC_ALARM)
    begin
      r.value = {15'h0000, lin[li[2:0]]};
    end
    else
    begin
      r.value = {15'h0000, s.alarm[sel[2:0]]};
    end
    src_fetch = r;
  endfunction

  // register read mux
  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    logic [31:0] d;
    logic [2:0] ch;
    d = '0;
    ch = a[6:4];
    if (a[11:7] == `PCC_OFS_CH_BASE >> 7)
    begin
      case (a[3:2])
        `PCC_CH_FLD_CFG: d = {23'h000000, cfg_q[ch]};
        `PCC_CH_FLD_SETPOINT: d = {16'h0000, setpoint_q[ch]};
        `PCC_CH_FLD_HYST: d = {16'h0000, hyst_q[ch]};
        default: d = {16'h0000, delay_q[ch]};
      endcase
    end
    else
    begin
      case (a)
        `PCC_OFS_CTRL: d[`PCC_CTRL_POWER_BIT] = power_q;
        `PCC_OFS_MODE: d[15:0] = {mode_q[7], mode_q[6], mode_q[5], mode_q[4], mode_q[3], mode_q[2], mode_q[1], mode_q[0]};
        `PCC_OFS_STATE:
        begin
          d[7:0] = relay_q;
          d[`PCC_STATE_AUTO_LSB +: 8] = {mode_q[7] == MODE_AUTO, mode_q[6] == MODE_AUTO, mode_q[5] == MODE_AUTO,
                                        mode_q[4] == MODE_AUTO, mode_q[3] == MODE_AUTO, mode_q[2] == MODE_AUTO,
                                        mode_q[1] == MODE_AUTO, mode_q[0] == MODE_AUTO};
          d[`PCC_STATE_POWER_BIT] = power_q;
        end
        `PCC_OFS_INT_STATUS: d[7:0] = int_stat_q;
        `PCC_OFS_INT_MASK: d[7:0] = int_mask_q;
        default: d = '0;
      endcase
    end
    rd_mux = d;
  endfunction

  assign wr_en = wr_pend_q;
  assign w1c_clr = (wr_en && wr_addr_q == `PCC_OFS_INT_STATUS) ? hwdata[7:0] : 8'h00;

  // address phase capture; writes finish with no wait, reads take one wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rd_pend_q <= 1'b0;
      rd_addr_q <= 12'h000;
      hready_q <= 1'b1;
    end
    else
    begin
      wr_pend_q <= take(hsel, htrans, hready) && hwrite;
      if (take(hsel, htrans, hready))
      begin
        // only offsets inside the 4 KiB window map, channel fields ignoring the low two bits; others hit no register
        if (hwrite)
          wr_addr_q <= (haddr[31:12] == 20'h00000) ? haddr[11:0] : 12'hFFC;
        else
          rd_addr_q <= (haddr[31:12] == 20'h00000) ? haddr[11:0] : 12'hFFC;
      end
      rd_pend_q <= take(hsel, htrans, hready) && !hwrite;
      hready_q <= !(take(hsel, htrans, hready) && !hwrite);
    end
  end

  // read data, loaded in the wait cycle so earlier writes are already visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h00000000;
    else if (rd_pend_q)
      hrdata_q <= rd_mux(rd_addr_q);
  end

  // turn-on command; reset stands for power loss, the device then stays off
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      power_q <= 1'b0;
    else if (wr_en && wr_addr_q == `PCC_OFS_CTRL)
      power_q <= hwdata[`PCC_CTRL_POWER_BIT];
  end

  // interrupt mask
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      int_mask_q <= `PCC_RST_MASK;
    else if (wr_en && wr_addr_q == `PCC_OFS_INT_MASK)
      int_mask_q <= hwdata[7:0];
  end

  // sticky change events; a new event beats a same-cycle clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_stat_q <= 8'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      int_stat_q <= (int_stat_q & ~w1c_clr) | change_ev;
      irq_q <= |(((int_stat_q & ~w1c_clr) | change_ev) & int_mask_q);
    end
  end

  // logic input pins pass two flip-flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lin_meta_q <= 7'h00;
      lin_q <= 7'h00;
    end
    else
    begin
      lin_meta_q <= logic_in_pins;
      lin_q <= lin_meta_q;
    end
  end

  // millisecond tick for rule delays
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end
    else if (tick_cnt_q >= 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // one slice per channel
  generate
    for (genvar i = 0; i < `PCC_NCH; i++)
    begin : g_ch
      src_sample_t smp; // selected source sample
      logic [16:0] lo_lim; // setpoint minus hysteresis, bit 16 set on borrow
      logic [16:0] hi_lim; // setpoint plus hysteresis
      logic act_cond; // activation condition
      logic deact_cond; // deactivation condition
      logic delay_done; // delay elapsed on this tick
      logic [11:0] blk; // this channel's block offset

      assign blk = 12'(`PCC_OFS_CH_BASE + 16 * i);
      assign smp = src_fetch(cfg_q[i].src, sources, health, lin_q);
      assign lo_lim = {1'b0, setpoint_q[i]} - {1'b0, hyst_q[i]};
      assign hi_lim = {1'b0, setpoint_q[i]} + {1'b0, hyst_q[i]};
      // polarity 1 acts above the setpoint, 0 below
      assign act_cond = cfg_q[i].polarity ? (smp.value > setpoint_q[i]) : (smp.value < setpoint_q[i]);
      assign deact_cond = cfg_q[i].polarity ? (!lo_lim[16] && {1'b0, smp.value} < lo_lim)
                                            : ({1'b0, smp.value} > hi_lim);
      assign delay_done = tick_q && (cnt_q[i] + 16'h0001 >= delay_q[i]);
      assign chan_on[i] = st_q[i][1];

      // mode selection, cleared while the device is off
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          mode_q[i] <= MODE_MAN_OFF;
        else if (!power_q)
          mode_q[i] <= MODE_MAN_OFF;
        else if (wr_en && wr_addr_q == `PCC_OFS_MODE)
          mode_q[i] <= mode_decode(hwdata[2 * i +: 2]);
      end

      // rule registers
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cfg_q[i] <= '0;
          setpoint_q[i] <= `PCC_RST_WORD16;
          hyst_q[i] <= `PCC_RST_WORD16;
          delay_q[i] <= `PCC_RST_WORD16;
        end
        else if (wr_en && wr_addr_q[11:4] == blk[11:4])
        begin
          case (wr_addr_q[3:2])
            `PCC_CH_FLD_CFG: cfg_q[i] <= hwdata[8:0];
            `PCC_CH_FLD_SETPOINT: setpoint_q[i] <= hwdata[15:0];
            `PCC_CH_FLD_HYST: hyst_q[i] <= hwdata[15:0];
            default: delay_q[i] <= hwdata[15:0];
          endcase
        end
      end

      // channel state machine and delay counter
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          st_q[i] <= ST_INACTIVE;
          cnt_q[i] <= 16'h0000;
        end
        else if (mode_q[i] != MODE_AUTO)
        begin
          // manual selection forces the state at once
          st_q[i] <= (mode_q[i] == MODE_MAN_ON) ? ST_ACTIVE : ST_INACTIVE;
          cnt_q[i] <= 16'h0000;
        end
        else if (smp.fail)
        begin
          st_q[i] <= cfg_q[i].fallback ? ST_ACTIVE : ST_INACTIVE;
          cnt_q[i] <= 16'h0000;
        end
        else if (!smp.freeze)
        begin
          case (st_q[i])
            ST_INACTIVE:
            begin
              cnt_q[i] <= 16'h0000;
              if (act_cond)
                st_q[i] <= (delay_q[i] == 16'h0000) ? ST_ACTIVE : ST_ARMING;
            end
            ST_ARMING:
            begin
              if (!act_cond)
              begin
                st_q[i] <= ST_INACTIVE;
                cnt_q[i] <= 16'h0000;
              end
              else if (delay_done)
              begin
                st_q[i] <= ST_ACTIVE;
                cnt_q[i] <= 16'h0000;
              end
              else if (tick_q)
                cnt_q[i] <= cnt_q[i] + 16'h0001;
            end
            ST_ACTIVE:
            begin
              cnt_q[i] <= 16'h0000;
              if (deact_cond)
                st_q[i] <= (delay_q[i] == 16'h0000) ? ST_INACTIVE : ST_RELEASING;
            end
            ST_RELEASING:
            begin
              if (!deact_cond)
              begin
                st_q[i] <= ST_ACTIVE;
                cnt_q[i] <= 16'h0000;
              end
              else if (delay_done)
              begin
                st_q[i] <= ST_INACTIVE;
                cnt_q[i] <= 16'h0000;
              end
              else if (tick_q)
                cnt_q[i] <= cnt_q[i] + 16'h0001;
            end
            default:
            begin
              st_q[i] <= ST_INACTIVE;
              cnt_q[i] <= 16'h0000;
            end
          endcase
        end
      end

      // change event and audio pulse on the output transition
      assign change_ev[i] = (chan_on[i] && power_q) != relay_q[i];

      // pin drivers; while off every relay is released
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          relay_q[i] <= 1'b0;
          logic_n_q[i] <= 1'b1;
          led_q[i] <= 1'b0;
          audio_q[i] <= 1'b0;
        end
        else
        begin
          relay_q[i] <= chan_on[i] && power_q;
          logic_n_q[i] <= !(chan_on[i] && power_q);
          led_q[i] <= chan_on[i] && power_q;
          audio_q[i] <= change_ev[i] && (relay_q[i] ? cfg_q[i].audio_deact : cfg_q[i].audio_act);
        end
      end
    end
  endgenerate

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = 1'b0;
  assign relay_drive = relay_q;
  assign logic_out_n = logic_n_q;
  assign led = led_q;
  assign audio_alert = audio_q;
  assign powered = power_q;
  assign irq = irq_q;

endmodule

// >>> verification/pcc_plant.sv
`timescale 1ns/1ps
// far-side equipment: sensors, analog ports, logic lines and the switched loads
module pcc_plant (
  input wire logic hclk,
  input wire process_control_channels_pkg::sources_t set_src,
  input wire process_control_channels_pkg::health_t set_health,
  input wire logic [5:0] set_pins,
  input wire logic [7:0] relay_drive,
  input wire logic [7:0] logic_out_n,
  input wire logic [7:0] led,
  output process_control_channels_pkg::sources_t sources,
  output process_control_channels_pkg::health_t health,
  output logic [6:0] logic_in_pins,
  output logic miswired
);
  import process_control_channels_pkg::*;
  logic bad_q = 1'b0; // sticky: a load saw relay, line and lamp disagree
  // readings and instrument health settle one cycle after the bench moves them
  always_ff @(posedge hclk)
  begin
    sources <= set_src;
    health <= set_health;
  end
  // logic input 0 is wired back from the logic output of channel 1
  assign logic_in_pins = {set_pins, ~logic_out_n[1]};
  // loads compare contact, logic line and lamp of every channel
  always @(posedge hclk)
  begin
    if (relay_drive !== ~logic_out_n || led !== relay_drive)
      bad_q <= 1'b1;
  end
  assign miswired = bad_q;
endmodule

// >>> verification/pcc_chk.sv
`timescale 1ns/1ps
// watches the register bus and the channel outputs from outside
module pcc_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [7:0] relay_drive,
  input wire logic [7:0] logic_out_n,
  input wire logic [7:0] led,
  input wire logic powered
);
  logic take; // address phase accepted at this edge
  logic wr_ctrl_q; // data phase of a control write
  logic wr_mode_q; // data phase of a mode write
  assign take = hsel && htrans[1] && hready;
  // remember which register the running data phase targets
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ctrl_q <= 1'b0;
      wr_mode_q <= 1'b0;
    end
    else if (hready)
    begin
      wr_ctrl_q <= take && hwrite && haddr == 32'h00000000;
      wr_mode_q <= take && hwrite && haddr == 32'h00000004;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  relay_pair_a: assert property (relay_drive == ~logic_out_n && led == relay_drive)
    else $error("relay, logic output and lamp disagree");
  reset_relays_a: assert property (disable iff (1'b0) !hresetn |-> relay_drive == 8'h00 && !powered)
    else $error("relays energized during reset");
  fresh_start_a: assert property ($rose(hresetn) |-> relay_drive == 8'h00 && !powered)
    else $error("device not off and inactive after reset");
  off_relays_a: assert property ((!powered) [*4] |-> relay_drive == 8'h00)
    else $error("relay energized while device off");
  power_cause_a: assert property ($rose(powered) |-> $past(wr_ctrl_q && hwdata[0]))
    else $error("device turned on without a command");
  manual_on_a: assert property (wr_mode_q && powered && hwdata[1:0] == 2'b01 |-> ##3 relay_drive[0])
    else $error("manual active not applied");
  manual_off_a: assert property (wr_mode_q && powered && hwdata[1:0] == 2'b00 |-> ##3 !relay_drive[0])
    else $error("manual inactive not applied");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
endmodule
bind process_control_channels pcc_chk u_pcc_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .relay_drive(relay_drive), .logic_out_n(logic_out_n), .led(led), .powered(powered));

// >>> verification/tb_process_control_channels.sv
`timescale 1ns/1ps
`include "process_control_channels_params.svh"
module tb_process_control_channels;
  import process_control_channels_pkg::*;
  typedef struct packed {logic [31:0] mode; logic [7:0] relay; logic irq;} row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata, q;
  logic hreadyout, hready, hresp, powered, irq, miswired;
  sources_t sources;
  sources_t set_src = '0; // plant readings chosen by the bench
  health_t health;
  health_t set_health = '0; // plant health chosen by the bench
  logic [6:0] logic_in_pins;
  logic [7:0] relay_drive, logic_out_n, led, audio_alert, prev;
  logic saw_audio = 1'b0; // any audio pulse on channel 0
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int i;
  // manual mode word, relays, irq with only channel 0 unmasked
  row_t rows [5] = '{'{32'h00000001, 8'h01, 1'b1}, '{32'h00005555, 8'hFF, 1'b0},
    '{32'h0000AAAA, 8'h00, 1'b1}, '{32'h00004001, 8'h81, 1'b1}, '{32'h00000000, 8'h00, 1'b1}};
  // channels 1-6: voltage, analyzer, logic input, alarm, clock, manometer
  logic [7:0] cfgs [7] = '{8'h00, 8'h08, 8'h20, 8'h31, 8'h38, 8'h30, 8'h0C};
  logic [7:0] sps [7] = '{8'h00, 8'h64, 8'h64, 8'h00, 8'h00, 8'h05, 8'h64};
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  process_control_channels #(.TICK_CYCLES(4)) u_process_control_channels (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sources(sources),
    .health(health), .logic_in_pins(logic_in_pins), .relay_drive(relay_drive), .logic_out_n(logic_out_n),
    .led(led), .audio_alert(audio_alert), .powered(powered), .irq(irq));
  pcc_plant u_pcc_plant (.hclk(hclk), .set_src(set_src), .set_health(set_health), .set_pins(6'h00),
    .relay_drive(relay_drive), .logic_out_n(logic_out_n), .led(led), .sources(sources), .health(health),
    .logic_in_pins(logic_in_pins), .miswired(miswired));
  // one word transfer, entered and left just after a rising edge; read data lands in q
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    htrans <= 2'b10;
    @(negedge hclk);
    for (n = 0; n < 20 && hready !== 1'b1; n++) @(negedge hclk);
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(negedge hclk);
    for (n = 0; n < 20 && hready !== 1'b1; n++) @(negedge hclk);
    q = hrdata;
    @(posedge hclk);
  endtask
  // count and report one comparison
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // read a register and compare
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk($sformatf("reg %h", a), exp, q);
  endtask
  // program one channel rule block
  task automatic rule(input int ch, input logic [15:0] cfg, input logic [15:0] sp, input logic [15:0] hy,
                      input logic [15:0] dl);
    xfer(1'b1, `PCC_OFS_CH_BASE + 12'(ch * 16), {16'h0000, cfg});
    xfer(1'b1, `PCC_OFS_CH_BASE + 12'(ch * 16 + 4), {16'h0000, sp});
    xfer(1'b1, `PCC_OFS_CH_BASE + 12'(ch * 16 + 8), {16'h0000, hy});
    xfer(1'b1, `PCC_OFS_CH_BASE + 12'(ch * 16 + 12), {16'h0000, dl});
  endtask
  // compare all relays between edges
  task automatic outs(input logic [7:0] exp);
    @(negedge hclk);
    chk("relay_drive", {24'h000000, exp}, {24'h000000, relay_drive});
    @(posedge hclk);
  endtask
  // hold: relay stays at v for max cycles; otherwise it must reach v within max
  task automatic relay_at(input int b, input logic v, input int max, input logic hold);
    int n;
    logic ok;
    ok = 1'b1;
    for (n = 0; n < max; n++)
    begin
      @(negedge hclk);
      if (hold && relay_drive[b] !== v) ok = 1'b0;
      if (!hold && relay_drive[b] === v) n = max;
    end
    if (!hold) ok = relay_drive[b] === v;
    chk($sformatf("relay %0d", b), 32'h00000001, {31'h0, ok});
    @(posedge hclk);
  endtask
  // verdict and end of run
  task automatic summarize();
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // audio pulses seen on channel 0
  always @(negedge hclk)
    if (audio_alert[0] === 1'b1) saw_audio <= 1'b1;
  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    hresetn <= 1'b0; // negedge at time zero
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 5; i++) rdc(12'(i * 4), 32'h00000000);
    xfer(1'b1, 12'hFFC, 32'h0000FFFF);
    rdc(12'hFFC, 32'h00000000);
    xfer(1'b1, `PCC_OFS_MODE, 32'h00005555);
    rdc(`PCC_OFS_MODE, 32'h00000000);
    outs(8'h00);
    xfer(1'b1, `PCC_OFS_CTRL, 32'h00000001);
    rdc(`PCC_OFS_STATE, 32'h00010000);
    xfer(1'b1, `PCC_OFS_INT_MASK, 32'h00000001);
    prev = 8'h00;
    for (i = 0; i < 5; i++)
    begin
      xfer(1'b1, `PCC_OFS_MODE, rows[i].mode);
      repeat (3) @(posedge hclk);
      outs(rows[i].relay);
      @(negedge hclk);
      chk("irq", {31'h0, rows[i].irq}, {31'h0, irq});
      @(posedge hclk);
      rdc(`PCC_OFS_STATE, {15'h0000, 1'b1, 8'h00, rows[i].relay});
      rdc(`PCC_OFS_INT_STATUS, {24'h000000, rows[i].relay ^ prev});
      xfer(1'b1, `PCC_OFS_INT_STATUS, 32'h000000FF);
      rdc(`PCC_OFS_INT_STATUS, 32'h00000000);
      prev = rows[i].relay;
    end
    rule(0, 16'h00A4, 16'h0064, 16'h000A, 16'h0004);
    rdc(`PCC_OFS_CH_BASE + 12'h004, 32'h00000064);
    set_src.pressure[4] <= 16'h0032;
    xfer(1'b1, `PCC_OFS_MODE, 32'h00000003);
    relay_at(0, 1'b0, 20, 1'b1);
    rdc(`PCC_OFS_STATE, 32'h00010100);
    set_src.pressure[4] <= 16'h00C8;
    relay_at(0, 1'b0, 6, 1'b1);
    set_src.pressure[4] <= 16'h0032;
    relay_at(0, 1'b0, 20, 1'b1);
    set_src.pressure[4] <= 16'h00C8;
    relay_at(0, 1'b0, 14, 1'b1);
    relay_at(0, 1'b1, 30, 1'b0);
    chk("audio", 32'h00000001, {31'h0, saw_audio});
    set_src.pressure[4] <= 16'h005F;
    relay_at(0, 1'b1, 40, 1'b1);
    set_src.pressure[4] <= 16'h0050;
    relay_at(0, 1'b0, 40, 1'b0);
    xfer(1'b1, `PCC_OFS_CH_BASE, 32'h000000E4);
    set_health.pressure_fail[4] <= 1'b1;
    relay_at(0, 1'b1, 6, 1'b0);
    set_health.pressure_fail[4] <= 1'b0;
    relay_at(0, 1'b0, 40, 1'b0);
    for (i = 1; i < 7; i++) rule(i, {8'h00, cfgs[i]}, {8'h00, sps[i]}, 16'h0000, 16'h0000);
    set_src.alarm <= 8'h01;
    set_src.clock_minutes <= 16'h000A;
    xfer(1'b1, `PCC_OFS_INT_STATUS, 32'h000000FF);
    xfer(1'b1, `PCC_OFS_MODE, 32'h00003FFF);
    repeat (12) @(posedge hclk);
    outs(8'h7A);
    set_health.gas_analyzer_head_busy <= 1'b1;
    set_src.pressure[0] <= 16'h00C8;
    relay_at(2, 1'b0, 20, 1'b1);
    set_health.gas_analyzer_head_busy <= 1'b0;
    relay_at(2, 1'b1, 10, 1'b0);
    set_health.analog_is_output[0] <= 1'b1;
    relay_at(1, 1'b0, 6, 1'b0);
    relay_at(3, 1'b1, 10, 1'b1);
    set_health.analog_overload[4] <= 1'b1;
    relay_at(6, 1'b0, 6, 1'b0);
    xfer(1'b1, `PCC_OFS_CTRL, 32'h00000000);
    repeat (4) @(posedge hclk);
    outs(8'h00);
    rdc(`PCC_OFS_MODE, 32'h00000000);
    xfer(1'b1, `PCC_OFS_CTRL, 32'h00000001);
    repeat (6) @(posedge hclk);
    outs(8'h00);
    xfer(1'b1, `PCC_OFS_MODE, 32'h00000001);
    repeat (3) @(posedge hclk);
    outs(8'h01);
    hresetn <= 1'b0;
    outs(8'h00);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(`PCC_OFS_CTRL, 32'h00000000);
    rdc(`PCC_OFS_MODE, 32'h00000000);
    chk("plant wiring", 32'h00000000, {31'h0, miswired});
    chk("hresp", 32'h00000000, {31'h0, hresp});
    summarize();
  end
endmodule
